// ---- pkg/gcimc_defines.vh ----
// constants for the gci monitor and command/indication channel controllers
`ifndef GCIMC_DEFINES_VH
`define GCIMC_DEFINES_VH

// ****************************************************
// register map
// ****************************************************
`define GCIMC_ADDR_W        12
`define GCIMC_A_MON_RXBD    12'h73A
`define GCIMC_A_MON_TXBD    12'h73C
`define GCIMC_A_CI_RXBD     12'h73E
`define GCIMC_A_CI_TXBD     12'h740
`define GCIMC_A_MODE        12'h7F0
`define GCIMC_A_CMD         12'h7F2

// ****************************************************
// mode word fields, command bits and reset
// ****************************************************
`define GCIMC_MODE_RST      16'h3500
`define GCIMC_MODE_WMASK    16'hFF97
`define GCIMC_B_MON_EN      0
`define GCIMC_B_CI_EN       1
`define GCIMC_B_LOOP        2
`define GCIMC_B_PROT        4
`define GCIMC_B_CMD_ABORT   0
`define GCIMC_B_CMD_TMO     1

// ****************************************************
// descriptor fields
// ****************************************************
`define GCIMC_B_FLAG        15
`define GCIMC_B_LAST        14
`define GCIMC_B_MS          12
`define GCIMC_B_AB          9
`define GCIMC_B_EB          8
`define GCIMC_CI_HI         5
`define GCIMC_CI_LO         2

// ****************************************************
// frame layout and timing
// ****************************************************
`define GCIMC_LAST_BIT      4'hD
`define GCIMC_PRELAST_BIT   4'hC
`define GCIMC_ABORT_FRAMES  2'h2
`define GCIMC_DIAG_LOOPCTL  2'h3
`endif

// ---- rtl/gcimc_ci_det.v ----
// command/indication change detector, double-frame confirmation
`timescale 1ns/1ns
module gcimc_ci_det #(
  parameter W = 4
) (
  input  wire         clk,
  input  wire         rstN,
  input  wire         enable,
  input  wire         frameDone,
  input  wire [W-1:0] code,
  output reg          validStb,
  output reg  [W-1:0] validCode
);
  reg [W-1:0] lastCode_ff;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      lastCode_ff <= {W{1'b0}};
      validCode   <= {W{1'b0}};
      validStb    <= 1'b0;
    end else begin
      validStb <= 1'b0;
      if (enable && frameDone) begin
        lastCode_ff <= code;
        // a single corrupted frame never reaches software
        if (code != validCode && code == lastCode_ff) begin
          validCode <= code;
          validStb  <= 1'b1;
        end
      end
    end
  end
endmodule

// ---- rtl/gcimc_sync.v ----
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
module gcimc_sync #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rstN,
  input  wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage1_ff;
  reg [W-1:0] stage2_ff;

  // first stage feeds only the second stage
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      stage1_ff <= {W{1'b0}};
      stage2_ff <= {W{1'b0}};
    end else begin
      stage1_ff <= din;
      stage2_ff <= stage1_ff;
    end
  end

  assign dout = stage2_ff;
endmodule

// ---- rtl/gcimc_top.v ----
// gci monitor and command/indication management channel controllers
`timescale 1ns/1ns
`include "gcimc_defines.vh"
module gcimc_top (
  input  wire        clk,
  input  wire        nrst,
  input  wire [11:0] regAddr,
  input  wire [15:0] regWdata,
  input  wire        regWr,
  input  wire        regRd,
  output reg  [15:0] regRdata,
  input  wire        gciMode,
  input  wire [1:0]  serialDiagField,
  input  wire        layer1BitClock,
  input  wire        frameSync,
  input  wire        layer1RxPin,
  output reg         layer1TxPin,
  output reg         layer1TxPinOe,
  output reg         monRxIrq,
  output reg         monTxIrq,
  output reg         ciRxIrq,
  output reg         ciTxIrq
);
  // ****************************************************
  // reset release
  // ****************************************************
  reg        rstMeta_ff;
  reg        rstN_ff;
  wire       rstN;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_ff <= 1'b0;
      rstN_ff    <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstN_ff    <= rstMeta_ff;
    end
  end
  assign rstN = rstN_ff;

  // ****************************************************
  // declarations
  // ****************************************************
  wire [2:0]  pinSync;
  wire        bitClkS;
  wire        fsyncS;
  wire        rxdS;
  reg         bitClkPrev_ff;
  wire        bitRise;
  wire        bitFall;
  reg  [3:0]  bitCnt_ff;
  reg         inFrame_ff;
  reg         frameDone_ff;
  reg  [13:0] rxShift_ff;
  reg  [13:0] txFrame_ff;
  wire [13:0] txVec;
  wire        loopBit;
  wire        rxBit;

  reg  [15:0] mode_ff;
  wire        monEn;
  wire        ciEn;
  wire        protSel;
  wire        loopSel;

  reg         monRxEmpty_ff;
  reg         monRxLast_ff;
  reg         monRxMs_ff;
  reg         monRxAb_ff;
  reg         monRxEb_ff;
  reg  [7:0]  monRxData_ff;
  reg         monTxReady_ff;
  reg         monTxLast_ff;
  reg         monTxAb_ff;
  reg         monTxEb_ff;
  reg  [7:0]  monTxData_ff;
  reg         ciRxEmpty_ff;
  reg  [3:0]  ciRxCode_ff;
  reg         ciTxReady_ff;
  reg  [3:0]  ciTxCode_ff;

  localparam TX_IDLE = 2'h0;
  localparam TX_SEND = 2'h1;
  localparam TX_GAP  = 2'h2;
  reg  [1:0]  txState_ff;
  reg  [1:0]  tmoCnt_ff;
  reg  [1:0]  abortCnt_ff;
  reg         sentReady_ff;
  reg  [7:0]  lastMon_ff;
  reg         stored_ff;
  reg         rxActive_ff;
  reg         rxEPrev_ff;

  wire [7:0]  rMon;
  wire [3:0]  rCi;
  wire        rA;
  wire        rE;
  wire        cmdWr;
  wire        abortCmd;
  wire        tmoCmd;
  wire        ciValid;
  wire [3:0]  ciCode;
  reg         aOut;
  reg         eOut;
  reg  [7:0]  monOut;

  // ****************************************************
  // pin synchronisers and bit clock edges
  // ****************************************************
  gcimc_sync #(
    .W    (3)
  ) u_sync (
    .clk  (clk),
    .rstN (rstN),
    .din  ({layer1BitClock, frameSync, layer1RxPin}),
    .dout (pinSync)
  );
  assign bitClkS = pinSync[2];
  assign fsyncS  = pinSync[1];
  assign rxdS    = pinSync[0];
  assign bitRise = bitClkS & ~bitClkPrev_ff;
  assign bitFall = ~bitClkS & bitClkPrev_ff;

  // ****************************************************
  // mode word decode
  // ****************************************************
  assign monEn   = mode_ff[`GCIMC_B_MON_EN] & gciMode;
  assign ciEn    = mode_ff[`GCIMC_B_CI_EN] & gciMode;
  assign protSel = mode_ff[`GCIMC_B_PROT];
  assign loopSel = mode_ff[`GCIMC_B_LOOP] & monEn & ciEn;

  // ****************************************************
  // frame timing
  // ****************************************************
  // bits: monitor msb first, c/i msb first, then A, then E
  assign txVec   = {monOut, ciTxCode_ff, aOut, eOut};
  // bit 0 is sampled on the same edge that latches the frame
  assign loopBit = fsyncS ? txVec[13] : txFrame_ff[4'hC - bitCnt_ff];
  assign rxBit   = loopSel ? loopBit : rxdS;

  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      bitClkPrev_ff <= 1'b0;
      bitCnt_ff     <= 4'h0;
      inFrame_ff    <= 1'b0;
      frameDone_ff  <= 1'b0;
      rxShift_ff    <= 14'h3FFF;
      txFrame_ff    <= 14'h3FFF;
      layer1TxPin   <= 1'b1;
      layer1TxPinOe <= 1'b0;
    end else begin
      bitClkPrev_ff <= bitClkS;
      frameDone_ff  <= 1'b0;
      if (bitRise) begin
        // all channel timing runs off the layer-1 bit clock
        if (fsyncS) begin
          bitCnt_ff  <= 4'h0;
          inFrame_ff <= 1'b1;
          txFrame_ff <= txVec;
          rxShift_ff <= {rxShift_ff[12:0], rxBit};
        end else if (inFrame_ff && bitCnt_ff != `GCIMC_LAST_BIT) begin
          bitCnt_ff    <= bitCnt_ff + 4'h1;
          rxShift_ff   <= {rxShift_ff[12:0], rxBit};
          frameDone_ff <= (bitCnt_ff == `GCIMC_PRELAST_BIT);
        end else begin
          inFrame_ff <= 1'b0;
        end
      end
      if (bitFall) begin
        layer1TxPin   <= txFrame_ff[4'hD - bitCnt_ff];
        // pin released outside the channel slot
        layer1TxPinOe <= inFrame_ff && (monEn || ciEn) &&
                         serialDiagField != `GCIMC_DIAG_LOOPCTL;
      end
    end
  end

  assign rMon = rxShift_ff[13:6];
  assign rCi  = rxShift_ff[5:2];
  assign rA   = rxShift_ff[1];
  assign rE   = rxShift_ff[0];

  // ****************************************************
  // commands
  // ****************************************************
  assign cmdWr    = regWr && regAddr == `GCIMC_A_CMD;
  // one-cycle pulses, dropped unless the monitor is enabled in protocol mode in gci
  assign abortCmd = cmdWr && regWdata[`GCIMC_B_CMD_ABORT] &&
                    protSel && monEn;
  assign tmoCmd   = cmdWr && regWdata[`GCIMC_B_CMD_TMO] &&
                    protSel && monEn;

  // ****************************************************
  // monitor channel outgoing bits
  // ****************************************************
  always @* begin
    monOut = monTxData_ff;
    aOut   = 1'b1;
    eOut   = 1'b1;
    if (!protSel) begin
      aOut = monTxAb_ff;
      eOut = monTxEb_ff;
    end else begin
      // active-low E marks a byte on offer
      eOut = !(txState_ff == TX_SEND && tmoCnt_ff == 2'h0);
      // ack only once software has emptied the descriptor
      aOut = !(stored_ff && monRxEmpty_ff &&
               abortCnt_ff == 2'h0);
    end
  end

  // ****************************************************
  // monitor channel state
  // ****************************************************
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      txState_ff   <= TX_IDLE;
      tmoCnt_ff    <= 2'h0;
      abortCnt_ff  <= 2'h0;
      sentReady_ff <= 1'b0;
      lastMon_ff   <= 8'hFF;
      stored_ff    <= 1'b0;
      rxActive_ff  <= 1'b0;
      rxEPrev_ff   <= 1'b1;
    end else begin
      if (bitRise && fsyncS) begin
        sentReady_ff <= monTxReady_ff;
      end
      if (tmoCmd) begin
        tmoCnt_ff  <= `GCIMC_ABORT_FRAMES;
        txState_ff <= TX_IDLE;
      end else if (frameDone_ff && monEn && protSel) begin
        if (tmoCnt_ff != 2'h0) begin
          tmoCnt_ff <= tmoCnt_ff - 2'h1;
        end
        case (txState_ff)
          TX_IDLE: begin
            if (monTxReady_ff && tmoCnt_ff == 2'h0) begin
              txState_ff <= TX_SEND;
            end
          end
          TX_SEND: begin
            if (!rA) begin
              txState_ff <= TX_GAP;
            end
          end
          TX_GAP: begin
            txState_ff <= TX_IDLE;
          end
          default: begin
            txState_ff <= TX_IDLE;
          end
        endcase
      end else if (!monEn || !protSel) begin
        txState_ff <= TX_IDLE;
        tmoCnt_ff  <= 2'h0;
      end
      if (abortCmd) begin
        abortCnt_ff <= `GCIMC_ABORT_FRAMES;
      end else if (frameDone_ff && abortCnt_ff != 2'h0) begin
        abortCnt_ff <= abortCnt_ff - 2'h1;
      end
      if (frameDone_ff && monEn && protSel) begin
        rxEPrev_ff <= rE;
        if (!rE) begin
          rxActive_ff <= 1'b1;
          lastMon_ff  <= rMon;
          if (rMon != lastMon_ff) begin
            stored_ff <= 1'b0;
          end else if (monRxEmpty_ff) begin
            stored_ff <= 1'b1;
          end
        end else if (rxEPrev_ff) begin
          rxActive_ff <= 1'b0;
          stored_ff   <= 1'b0;
          lastMon_ff  <= 8'hFF;
        end
      end
    end
  end

  // ****************************************************
  // command/indication change detector
  // ****************************************************
  gcimc_ci_det #(
    .W         (4)
  ) u_ci_det (
    .clk       (clk),
    .rstN      (rstN),
    .enable    (ciEn),
    .frameDone (frameDone_ff),
    .code      (rCi),
    .validStb  (ciValid),
    .validCode (ciCode)
  );

  // ****************************************************
  // registers and descriptors
  // ****************************************************
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      mode_ff       <= `GCIMC_MODE_RST;
      monRxEmpty_ff <= 1'b1;
      monRxLast_ff  <= 1'b0;
      monRxMs_ff    <= 1'b0;
      monRxAb_ff    <= 1'b0;
      monRxEb_ff    <= 1'b0;
      monRxData_ff  <= 8'h00;
      monTxReady_ff <= 1'b0;
      monTxLast_ff  <= 1'b0;
      monTxAb_ff    <= 1'b1;
      monTxEb_ff    <= 1'b1;
      monTxData_ff  <= 8'hFF;
      ciRxEmpty_ff  <= 1'b1;
      ciRxCode_ff   <= 4'h0;
      ciTxReady_ff  <= 1'b0;
      ciTxCode_ff   <= 4'hF;
    end else begin
      // ready cleared by hardware first so a host set wins
      if (frameDone_ff && monEn) begin
        if (!protSel && sentReady_ff) begin
          monTxReady_ff <= 1'b0;
        end
        if (protSel && txState_ff == TX_SEND && !rA) begin
          monTxReady_ff <= 1'b0;
        end
      end
      if (frameDone_ff && ciEn) begin
        ciTxReady_ff <= 1'b0;
      end
      if (regWr) begin
        case (regAddr)
          `GCIMC_A_MODE: begin
            mode_ff <= regWdata & `GCIMC_MODE_WMASK;
          end
          `GCIMC_A_MON_RXBD: begin
            monRxEmpty_ff <= regWdata[`GCIMC_B_FLAG];
          end
          `GCIMC_A_MON_TXBD: begin
            monTxReady_ff <= regWdata[`GCIMC_B_FLAG];
            monTxLast_ff  <= regWdata[`GCIMC_B_LAST];
            monTxAb_ff    <= regWdata[`GCIMC_B_AB];
            monTxEb_ff    <= regWdata[`GCIMC_B_EB];
            monTxData_ff  <= regWdata[7:0];
          end
          `GCIMC_A_CI_RXBD: begin
            ciRxEmpty_ff <= regWdata[`GCIMC_B_FLAG];
          end
          `GCIMC_A_CI_TXBD: begin
            ciTxReady_ff <= regWdata[`GCIMC_B_FLAG];
            ciTxCode_ff  <= regWdata[`GCIMC_CI_HI:`GCIMC_CI_LO];
          end
          default: begin
          end
        endcase
      end
      // received data wins over a host write in the same cycle
      if (frameDone_ff && monEn && !protSel && monRxEmpty_ff) begin
        monRxData_ff  <= rMon;
        monRxAb_ff    <= rA;
        monRxEb_ff    <= rE;
        monRxLast_ff  <= 1'b0;
        monRxEmpty_ff <= 1'b0;
      end
      if (frameDone_ff && monEn && protSel) begin
        if (!rE) begin
          monRxMs_ff <= (rMon != lastMon_ff);
          if (rMon == lastMon_ff && !stored_ff && monRxEmpty_ff) begin
            monRxData_ff  <= rMon;
            monRxLast_ff  <= 1'b0;
            monRxEmpty_ff <= 1'b0;
          end
        end else if (rxEPrev_ff && rxActive_ff && monRxEmpty_ff) begin
          monRxLast_ff  <= 1'b1;
          monRxEmpty_ff <= 1'b0;
        end
      end
      if (ciValid && ciRxEmpty_ff) begin
        ciRxCode_ff  <= ciCode;
        ciRxEmpty_ff <= 1'b0;
      end
    end
  end

  // ****************************************************
  // read data and interrupt requests
  // ****************************************************
  always @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      regRdata <= 16'h0000;
      monRxIrq <= 1'b0;
      monTxIrq <= 1'b0;
      ciRxIrq  <= 1'b0;
      ciTxIrq  <= 1'b0;
    end else begin
      // full or empty descriptors raise requests only when enabled
      monRxIrq <= monEn && !monRxEmpty_ff;
      monTxIrq <= monEn && !monTxReady_ff;
      ciRxIrq  <= ciEn && !ciRxEmpty_ff;
      ciTxIrq  <= ciEn && !ciTxReady_ff;
      regRdata <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          `GCIMC_A_MODE: begin
            regRdata <= mode_ff;
          end
          `GCIMC_A_MON_RXBD: begin
            regRdata <= {monRxEmpty_ff, monRxLast_ff, 1'b0, monRxMs_ff,
                         2'h0, monRxAb_ff, monRxEb_ff, monRxData_ff};
          end
          `GCIMC_A_MON_TXBD: begin
            regRdata <= {monTxReady_ff, monTxLast_ff, 4'h0,
                         monTxAb_ff, monTxEb_ff, monTxData_ff};
          end
          `GCIMC_A_CI_RXBD: begin
            regRdata <= {ciRxEmpty_ff, 9'h000, ciRxCode_ff, 2'h0};
          end
          `GCIMC_A_CI_TXBD: begin
            regRdata <= {ciTxReady_ff, 9'h000, ciTxCode_ff, 2'h0};
          end
          default: begin
            regRdata <= 16'h0000;
          end
        endcase
      end
    end
  end
endmodule

// ---- tb/gcimc_l1_model.sv ----
// layer-1 transceiver model on the gci side of the management channels
`timescale 1ns/1ns
module gcimc_l1_model (
  output reg  bitClock,
  output reg  frameStart,
  output reg  rxData,
  input  wire txData,
  input  wire txOe
);
  // line is pulled up, so idle reads 1; clock rests low between frames
  initial begin
    bitClock = 1'b0;
    frameStart = 1'b0;
    rxData = 1'b1;
  end

  // ****************************************************
  // one 14-bit frame plus the closing rise
  // ****************************************************
  task runFrame(input [13:0] rxBits, output [13:0] txBits, output oeAny);
    integer k;
    begin
      oeAny = 1'b0;
      for (k = 0; k < 15; k = k + 1) begin
        rxData = (k < 14) ? rxBits[13-k] : 1'b1;
        frameStart = (k == 0);
        #80 bitClock = 1'b1;
        if (k > 0) txBits[14-k] = txData;
        oeAny = oeAny | txOe;
        #160 bitClock = 1'b0;
        #80;
      end
      frameStart = 1'b0;
    end
  endtask
endmodule

// ---- tb/gcimc_top_monitor.sv ----
// concurrent checks on the management channel controller ports
`timescale 1ns/1ns
module gcimc_top_monitor (
  input wire        clk,
  input wire        nrst,
  input wire [11:0] regAddr,
  input wire [15:0] regWdata,
  input wire        regWr,
  input wire        regRd,
  input wire [15:0] regRdata,
  input wire        gciMode,
  input wire [1:0]  serialDiagField,
  input wire        layer1TxPinOe,
  input wire        monRxIrq,
  input wire        monTxIrq,
  input wire        ciRxIrq,
  input wire        ciTxIrq
);
  reg [15:0] modeShadow_ff;

  // shadow of the mode word, only the writable bits survive
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      modeShadow_ff <= 16'h3500;
    end else if (regWr && regAddr == 12'h7F0) begin
      modeShadow_ff <= regWdata & 16'hFF97;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****************************************************
  // properties
  // ****************************************************
  sequence modeWrite;
    regWr && regAddr == 12'h7F0;
  endsequence
  sequence modeRead;
    regRd && regAddr == 12'h7F0;
  endsequence

  mode_readback_a: assert property (
    modeWrite ##1 !regWr ##1 modeRead |=>
      regRdata == ($past(regWdata, 3) & 16'hFF97))
    else $error("mode word readback differs from masked write");
  unmapped_read_a: assert property (
    !(regRd && regAddr inside {12'h73A, 12'h73C, 12'h73E, 12'h740,
      12'h7F0}) |=> regRdata == 16'h0000)
    else $error("read data not zero outside a mapped read");
  diag_quiet_a: assert property (
    serialDiagField == 2'h3 [*3] |-> !layer1TxPinOe)
    else $error("tx pin driven under loopback control");
  gci_quiet_a: assert property (
    !gciMode [*3] |-> !layer1TxPinOe)
    else $error("tx pin driven outside gci");
  mon_irq_gate_a: assert property (
    !modeShadow_ff[0] [*2] |-> !monRxIrq && !monTxIrq)
    else $error("monitor request while disabled");
  ci_irq_gate_a: assert property (
    !modeShadow_ff[1] [*2] |-> !ciRxIrq && !ciTxIrq)
    else $error("c/i request while disabled");
  ci_ready_irq_a: assert property (
    regWr && regAddr == 12'h740 && regWdata[15] |=> ##1 !ciTxIrq)
    else $error("c/i tx request stays after ready set");
  mon_fill_irq_a: assert property (
    regWr && regAddr == 12'h73A && regWdata[15] |=> ##1 !monRxIrq)
    else $error("monitor rx request stays after empty set");
endmodule

bind gcimc_top gcimc_top_monitor gcimc_top_monitor_inst (
  .clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
  .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .gciMode(gciMode),
  .serialDiagField(serialDiagField), .layer1TxPinOe(layer1TxPinOe),
  .monRxIrq(monRxIrq), .monTxIrq(monTxIrq), .ciRxIrq(ciRxIrq),
  .ciTxIrq(ciTxIrq));

// ---- tb/test_gcimc_top.sv ----
// self-checking bench for the gci management channel controllers
`timescale 1ns/1ns
module test_gcimc_top;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [11:0] regAddr = 12'h000;
  reg  [15:0] regWdata = 16'h0000;
  reg         regWr = 1'b0;
  reg         regRd = 1'b0;
  reg         gciMode = 1'b1;
  reg  [1:0]  diagField = 2'h0;
  wire [15:0] regRdata;
  wire        bitClock;
  wire        frameSync;
  wire        rxPin;
  wire        txPin;
  wire        txOe;
  wire [3:0]  irqs;
  integer     err_total = 0;
  integer     total_checks = 0;
  integer     cycles = 0;
  reg  [13:0] tv;
  reg         oe;

  gcimc_top gcimc_top_inst (.clk(clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .gciMode(gciMode), .serialDiagField(diagField),
    .layer1BitClock(bitClock), .frameSync(frameSync),
    .layer1RxPin(rxPin), .layer1TxPin(txPin), .layer1TxPinOe(txOe),
    .monRxIrq(irqs[3]), .monTxIrq(irqs[2]), .ciRxIrq(irqs[1]),
    .ciTxIrq(irqs[0]));
  gcimc_l1_model gcimc_l1_model_inst (.bitClock(bitClock),
    .frameStart(frameSync), .rxData(rxPin), .txData(txPin), .txOe(txOe));

  always #20 clk = ~clk;

  // a frame is about 120 clocks; the whole run needs under 4000
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      err_total = err_total + 1;
      results;
    end
  end

  // ****************************************************
  // tasks
  // ****************************************************
  task chk(input string nm, input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wr(input [11:0] a, input [15:0] d);
    begin
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [15:0] m, input [15:0] e, input string nm);
    begin
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 chk(nm, regRdata & m, e);
    end
  endtask
  task fr(input [13:0] r);
    gcimc_l1_model_inst.runFrame(r, tv, oe);
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
        $display("Finished cleanly");
      end else begin
        $display("Finished with errors");
      end
      $finish;
    end
  endtask

  // ****************************************************
  // tests
  // ****************************************************
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    repeat (4) @(posedge clk);
    rd(12'h7F0, 16'hFFFF, 16'h3500, "mode reset");
    rd(12'h73C, 16'hFFFF, 16'h03FF, "mon tx reset");
    rd(12'h100, 16'hFFFF, 16'h0000, "unmapped");
    wr(12'h7F0, 16'hFFFF);
    rd(12'h7F0, 16'hFFFF, 16'hFF97, "mode mask");
    wr(12'h7F0, 16'h0000);
    @(posedge clk);
    #1 chk("irqs off", {12'h0, irqs}, 16'h0000);
    $display("test registers done");
    // c/i code sent each frame; receiver needs two equal frames
    wr(12'h7F0, 16'h0002);
    wr(12'h740, 16'h8028);
    fr(14'h3FD7);
    chk("ci tx 1", {12'h0, tv[5:2]}, 16'h000A);
    rd(12'h73E, 16'h8000, 16'h8000, "ci rx once");
    chk("irqs ci 1", {12'h0, irqs}, 16'h0001);
    fr(14'h3FD7);
    chk("ci tx 2", {12'h0, tv[5:2]}, 16'h000A);
    rd(12'h73E, 16'hFFFF, 16'h0014, "ci rx twice");
    chk("irqs ci 2", {12'h0, irqs}, 16'h0003);
    $display("test command/indication done");
    // transparent monitor; timeout must be ignored here
    wr(12'h73E, 16'h8000);
    wr(12'h7F0, 16'h0003);
    wr(12'h73C, 16'h825A);
    wr(12'h7F2, 16'h0002);
    fr(14'h0F16);
    chk("mon tx", {6'h0, tv[13:6], tv[1:0]}, 16'h016A);
    rd(12'h73A, 16'h83FF, 16'h023C, "mon rx");
    chk("irqs mon", {12'h0, irqs}, 16'h000D);
    fr(14'h2654);
    chk("mon tx again", {6'h0, tv[13:6], tv[1:0]}, 16'h016A);
    rd(12'h73A, 16'h83FF, 16'h023C, "mon rx held");
    wr(12'h73A, 16'h8000);
    fr(14'h2654);
    rd(12'h73A, 16'h83FF, 16'h0099, "mon rx next");
    $display("test transparent done");
    // protocol: offer, ack, double receive, withheld ack, commands
    wr(12'h73A, 16'h8000);
    wr(12'h7F0, 16'h0013);
    wr(12'h73C, 16'h80A5);
    fr(14'h3FD7);
    chk("offer idle", {7'h0, tv[13:6], tv[0]}, 16'h014B);
    rd(12'h73C, 16'h8000, 16'h8000, "ready kept");
    fr(14'h3FD5);
    chk("offer", {7'h0, tv[13:6], tv[0]}, 16'h014A);
    rd(12'h73C, 16'h8000, 16'h0000, "ready cleared");
    fr(14'h1096);
    rd(12'h73A, 16'h8000, 16'h8000, "one copy");
    fr(14'h1096);
    rd(12'h73A, 16'h80FF, 16'h0042, "two copies");
    chk("irqs prot", {12'h0, irqs}, 16'h000D);
    fr(14'h1096);
    chk("ack withheld", {15'h0, tv[1]}, 16'h0001);
    wr(12'h73A, 16'h8000);
    wr(12'h7F2, 16'h0001);
    fr(14'h1096);
    chk("abort a", {15'h0, tv[1]}, 16'h0001);
    fr(14'h3FD7);
    fr(14'h3FD7);
    chk("ack given", {15'h0, tv[1]}, 16'h0000);
    wr(12'h73C, 16'h8077);
    wr(12'h7F2, 16'h0002);
    fr(14'h3FD7);
    fr(14'h3FD7);
    chk("timeout e", {15'h0, tv[0]}, 16'h0001);
    $display("test protocol done");
    // outside gci nothing is driven
    @(posedge clk) gciMode <= 1'b0;
    fr(14'h3FD7);
    chk("gci off", {15'h0, oe}, 16'h0000);
    @(posedge clk) gciMode <= 1'b1;
    // loopback with both enables, then loop control silences the pin
    wr(12'h73E, 16'h8000);
    wr(12'h7F0, 16'h0007);
    wr(12'h740, 16'h8024);
    fr(14'h3FD7);
    fr(14'h3FD7);
    rd(12'h73E, 16'hFFFF, 16'h0024, "loop rx");
    chk("loop pin", {12'h0, tv[5:2]}, 16'h0009);
    @(posedge clk) diagField <= 2'h3;
    fr(14'h3FD7);
    chk("loop ctl", {15'h0, oe}, 16'h0000);
    $display("test loopback done");
    results;
  end
endmodule
